/* File: shared/lcd_consts.svh */
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// panel geometry
`define LCD_NUM_BYTES      3
`define LCD_NUM_DIGITS     6
`define LCD_SEGS_PER_DIGIT 7
`define LCD_CODE_BITS      4

// backplane timing: rate of the system clock and of the backplane square wave
`define LCD_CLK_FREQ_HZ    250000000
`define LCD_BP_FREQ_HZ     80
// half period of the backplane in clock cycles, rounded down
`define LCD_BP_HALF_CYCLES (`LCD_CLK_FREQ_HZ / (2 * `LCD_BP_FREQ_HZ))

// segment patterns, bit 6 = a ... bit 0 = g, 1 = lit
`define LCD_PAT_0 7'h7E
`define LCD_PAT_1 7'h30
`define LCD_PAT_2 7'h6D
`define LCD_PAT_3 7'h79
`define LCD_PAT_4 7'h33
`define LCD_PAT_5 7'h5B
`define LCD_PAT_6 7'h5F
`define LCD_PAT_7 7'h70
`define LCD_PAT_8 7'h7F
`define LCD_PAT_9 7'h7B
`define LCD_PAT_A 7'h77
`define LCD_PAT_B 7'h1F
`define LCD_PAT_C 7'h4E
`define LCD_PAT_D 7'h3D
`define LCD_PAT_E 7'h4F
`define LCD_PAT_F 7'h47

// reset values
`define LCD_BYTE_RESET 8'h00
`define LCD_SEG_RESET  7'h00

`endif

/* File: shared/lcd_pkg.sv */
package lcd_pkg;
  typedef logic [3:0] digit_code_t;
  typedef logic [6:0] seg_pattern_t;
  typedef logic [7:0] data_byte_t;
endpackage

/* File: src/seg_decoder.sv */
`timescale 1ns/10ps
`include "lcd_consts.svh"

module seg_decoder (
  input  lcd_pkg::digit_code_t  code,
  output lcd_pkg::seg_pattern_t lit
);

  // hexadecimal decode, code bit 0 is the least significant
  always_comb begin
    case (code)
      4'h0:    lit = `LCD_PAT_0;
      4'h1:    lit = `LCD_PAT_1;
      4'h2:    lit = `LCD_PAT_2;
      4'h3:    lit = `LCD_PAT_3;
      4'h4:    lit = `LCD_PAT_4;
      4'h5:    lit = `LCD_PAT_5;
      4'h6:    lit = `LCD_PAT_6;
      4'h7:    lit = `LCD_PAT_7;
      4'h8:    lit = `LCD_PAT_8;
      4'h9:    lit = `LCD_PAT_9;
      4'hA:    lit = `LCD_PAT_A;
      4'hB:    lit = `LCD_PAT_B;
      4'hC:    lit = `LCD_PAT_C;
      4'hD:    lit = `LCD_PAT_D;
      4'hE:    lit = `LCD_PAT_E;
      4'hF:    lit = `LCD_PAT_F;
      default: lit = `LCD_SEG_RESET;
    endcase
  end

endmodule

/* File: src/lcd_seven_segment_driver.sv */
// Functional notes
// - three data bytes, each latched on the rising edge of its own strobe.
// - six four-bit digit codes, twenty-four bits, feed the segment decoders.
// - forty-two separate segment outputs, all driven continuously, never multiplexed.
// - one backplane output for the whole panel, always toggling, never static.
// - no digit multiplexing frequency reaches the segments, so nothing beats.
// - backplane square wave runs at about 80 Hz from the internal clock.
// - segment output is backplane xor lit; lit segments run in antiphase.
// - hex decode; zero all but g, one b c, two a b d e g.
`timescale 1ns/10ps
`include "lcd_consts.svh"

module lcd_seven_segment_driver #(
  parameter int unsigned BP_HALF_CYCLES = `LCD_BP_HALF_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        byte_strobe_first,
  input  wire logic        byte_strobe_second,
  input  wire logic        byte_strobe_third,
  input  wire logic [7:0]  byte_data_first,
  input  wire logic [7:0]  byte_data_second,
  input  wire logic [7:0]  byte_data_third,
  output logic      [41:0] segment_out,
  output logic             backplane_out
);

  localparam int NB = `LCD_NUM_BYTES;
  localparam int ND = `LCD_NUM_DIGITS;
  localparam int NS = `LCD_SEGS_PER_DIGIT;
  localparam int CW = (BP_HALF_CYCLES > 1) ? $clog2(BP_HALF_CYCLES) : 1;

  // the counter needs at least one cycle per half period
  if (BP_HALF_CYCLES < 1) begin : g_bad_half
    $error("BP_HALF_CYCLES must be at least one");
  end

  logic [NB-1:0]          strobe_pin;
  lcd_pkg::data_byte_t    data_pin   [NB];
  logic [NB-1:0]          strobe_s1_q, strobe_s2_q, strobe_prev_q;
  logic [NB-1:0]          strobe_s1_d, strobe_s2_d, strobe_prev_d;
  logic [NB-1:0]          strobe_edge;
  lcd_pkg::data_byte_t    data_s1_q  [NB];
  lcd_pkg::data_byte_t    data_s2_q  [NB];
  lcd_pkg::data_byte_t    byte_q     [NB];
  lcd_pkg::data_byte_t    byte_d     [NB];
  lcd_pkg::seg_pattern_t  lit        [ND];
  logic [CW-1:0]          cnt_q, cnt_d;
  logic                   bp_q, bp_d;
  logic [ND*NS-1:0]       seg_q, seg_d;

  assign strobe_pin  = {byte_strobe_third, byte_strobe_second, byte_strobe_first};
  assign data_pin[0] = byte_data_first;
  assign data_pin[1] = byte_data_second;
  assign data_pin[2] = byte_data_third;

  // strobe synchronisers plus an edge history stage; only stage two and the history stage are looked at
  always_comb begin
    strobe_s1_d   = strobe_pin;
    strobe_s2_d   = strobe_s1_q;
    strobe_prev_d = strobe_s2_q;
  end

  assign strobe_edge = strobe_s2_q & ~strobe_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_s1_q   <= '0;
      strobe_s2_q   <= '0;
      strobe_prev_q <= '0;
    end else begin
      strobe_s1_q   <= strobe_s1_d;
      strobe_s2_q   <= strobe_s2_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  // per byte: data synchroniser and the holding register; data shares the strobe latency,
  // so the host must hold the byte steady for a few cycles around its strobe edge
  for (genvar b = 0; b < NB; b++) begin : g_byte
    always_comb begin
      byte_d[b] = strobe_edge[b] ? data_s2_q[b] : byte_q[b];
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        data_s1_q[b] <= `LCD_BYTE_RESET;
        data_s2_q[b] <= `LCD_BYTE_RESET;
        byte_q[b]    <= `LCD_BYTE_RESET;
      end else begin
        data_s1_q[b] <= data_pin[b];
        data_s2_q[b] <= data_s1_q[b];
        byte_q[b]    <= byte_d[b];
      end
    end
  end

  // one decoder per digit, low nibble to the even digit, high nibble to the odd one
  for (genvar d = 0; d < ND; d++) begin : g_digit
    seg_decoder u_dec (
      .code (byte_q[d/2][4*(d%2) +: 4]),
      .lit  (lit[d])
    );
  end

  // backplane divider; a free-running square wave, so the panel never sees dc
  always_comb begin
    cnt_d = cnt_q + CW'(1);
    bp_d  = bp_q;
    if (cnt_q == CW'(BP_HALF_CYCLES - 1)) begin
      cnt_d = '0;
      bp_d  = ~bp_q;
    end
  end

  // segment drive: every segment has its own static wave, phase set by its lit state
  always_comb begin
    for (int d = 0; d < ND; d++) begin
      seg_d[d*NS +: NS] = lit[d] ^ {NS{bp_q}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      bp_q  <= 1'b0;
      seg_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      bp_q  <= bp_d;
      seg_q <= seg_d;
    end
  end

  // segments lag the backplane flop by one cycle; the panel cannot see 4 ns
  assign segment_out   = seg_q;
  assign backplane_out = bp_q;

  // checks
  latch_on_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_edge[0] |=> byte_q[0] == $past(data_s2_q[0]))
    else $error("first byte not latched on its strobe edge");

  byte_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !strobe_edge[1] |=> $stable(byte_q[1]))
    else $error("second byte changed without a strobe edge");

  bp_toggle_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(bp_q) |-> $past(cnt_q) == CW'(BP_HALF_CYCLES - 1))
    else $error("backplane toggled off the half period");

  bp_keeps_running_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q == CW'(BP_HALF_CYCLES - 1) |=> bp_q != $past(bp_q) && cnt_q == '0)
    else $error("backplane failed to toggle");

  // a strobe edge one cycle before the flip loads a byte on the flip edge that moves the segments too, so that case is left out
  seg_invert_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(bp_q) && $past(strobe_edge) == '0 |=> segment_out == ~$past(segment_out))
    else $error("segments did not follow the backplane phase");

  zero_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_q[0][3:0] == 4'h0 |=> segment_out[6:0] == (`LCD_PAT_0 ^ {7{$past(bp_q)}}))
    else $error("code zero decoded wrongly on digit zero");

  high_nibble_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_q[0][7:4] == 4'h1 |=> segment_out[13:7] == (`LCD_PAT_1 ^ {7{$past(bp_q)}}))
    else $error("high nibble does not drive digit one");

  top_digit_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_q[2][7:4] == 4'h2 |=> segment_out[41:35] == (`LCD_PAT_2 ^ {7{$past(bp_q)}}))
    else $error("digit five decoded wrongly");

  update_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_edge[2] ##1 !$changed(bp_q) |=> segment_out[34:28] == (lit[4] ^ {7{bp_q}}) || $changed(bp_q))
    else $error("digit four not updated after strobe");

  // the other two bytes load from their own synchroniser only on their own edge
  latch_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_edge[1] |=> byte_q[1] == $past(data_s2_q[1]))
    else $error("second byte not latched on its strobe edge");

  latch_third_a: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_edge[2] |=> byte_q[2] == $past(data_s2_q[2]))
    else $error("third byte not latched on its strobe edge");

  // a strobe on one byte must leave the others alone
  hold_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    !strobe_edge[0] |=> $stable(byte_q[0]))
    else $error("first byte changed without a strobe edge");

  hold_third_a: assert property (@(posedge clk) disable iff (!rst_n)
    !strobe_edge[2] |=> $stable(byte_q[2]))
    else $error("third byte changed without a strobe edge");

  // static drive: no new byte and no backplane flip means no segment moves;
  // the first cycle after reset is left out, the segment flops still hold their reset value
  seg_static_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !$changed(bp_q) && $past(strobe_edge) == '0 |=> $stable(segment_out))
    else $error("segments moved with no strobe and no backplane flip");

  // the divider never runs past the end of its half period
  cnt_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= CW'(BP_HALF_CYCLES - 1))
    else $error("backplane divider past its half period");

  // fixed decodes on the middle digits and on digit four
  eight_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_q[1][3:0] == 4'h8 |=> segment_out[20:14] == (`LCD_PAT_8 ^ {7{$past(bp_q)}}))
    else $error("code eight decoded wrongly on digit two");

  digit_three_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_q[1][7:4] == 4'h0 |=> segment_out[27:21] == (`LCD_PAT_0 ^ {7{$past(bp_q)}}))
    else $error("high nibble of the second byte does not drive digit three");

  digit_four_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_q[2][3:0] == 4'h4 |=> segment_out[34:28] == (`LCD_PAT_4 ^ {7{$past(bp_q)}}))
    else $error("code four decoded wrongly on digit four");

  cover_strobe_c: cover property (@(posedge clk) disable iff (!rst_n) strobe_edge[0]);
  cover_third_c:  cover property (@(posedge clk) disable iff (!rst_n) strobe_edge[2]);
  cover_bp_c:     cover property (@(posedge clk) disable iff (!rst_n) $rose(bp_q));
  cover_eight_c:  cover property (@(posedge clk) disable iff (!rst_n) byte_q[1][3:0] == 4'h8);
  cover_second_c: cover property (@(posedge clk) disable iff (!rst_n) strobe_edge[1]);

endmodule

/* File: verification/lcd_panel_model.sv */
`timescale 1ns/10ps
module lcd_panel_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [41:0] segment_out,
  input  wire logic        backplane_out,
  output logic      [41:0] lit
);
  logic bp_q;

  // segments follow the backplane one edge late, so compare against the delayed copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_q <= 1'b0;
    end else begin
      bp_q <= backplane_out;
    end
  end

  // a segment shows lit only when its drive opposes the backplane
  assign lit = segment_out ^ {42{bp_q}};
endmodule

/* File: verification/lcd_seven_segment_driver_tb.sv */
`timescale 1ns/10ps
module lcd_seven_segment_driver_tb;
  localparam int H = 8;
  localparam logic [6:0] PT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
                                     7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3D, 7'h4F, 7'h47};
  logic        clk;
  logic        rst_n;
  logic        bp;
  logic [2:0]  st;
  logic [7:0]  d [3];
  logic [7:0]  sh [3];
  logic [41:0] seg;
  logic [41:0] lit;
  int          n_mismatch;
  int          tests_run;
  int          seed;
  int          k;

  lcd_seven_segment_driver #(.BP_HALF_CYCLES(H)) u_lcd_seven_segment_driver (
    .clk(clk), .rst_n(rst_n), .byte_strobe_first(st[0]), .byte_strobe_second(st[1]),
    .byte_strobe_third(st[2]), .byte_data_first(d[0]), .byte_data_second(d[1]),
    .byte_data_third(d[2]), .segment_out(seg), .backplane_out(bp));

  lcd_panel_model u_lcd_panel_model (
    .clk(clk), .rst_n(rst_n), .segment_out(seg), .backplane_out(bp), .lit(lit));

  // clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // expected lit pattern from the shadow of the three bytes
  function automatic logic [41:0] expv();
    logic [41:0] e;
    for (int i = 0; i < 6; i++) e[7*i+:7] = PT[sh[i/2][4*(i%2)+:4]];
    return e;
  endfunction

  task automatic chk(input string nm, input logic [41:0] e, input logic [41:0] g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // data held 4 cycles each side of the strobe, wider than the synchroniser needs
  task automatic load(input int b, input logic [7:0] v);
    d[b] = v;
    repeat (4) @(negedge clk);
    st[b] = 1'b1;
    repeat (4) @(negedge clk);
    st[b] = 1'b0;
    repeat (4) @(negedge clk);
    sh[b] = v;
    chk("lit", expv(), lit);
  endtask

  // one half period of the backplane, glass must stay steady across the flip
  task automatic bp_period();
    logic b0;
    int   n;
    b0 = bp;
    for (n = 0; n < 4*H && bp === b0; n++) @(negedge clk);
    b0 = bp;
    for (n = 0; n < 4*H && bp === b0; n++) begin
      @(negedge clk);
      chk("lit steady", expv(), lit);
    end
    chk("bp half period", 42'(H), 42'(n));
    if (n == 4*H) wrap_up();
  endtask

  // watchdog so a hang still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    seed = 32'h95a3_4f4a;
    rst_n = 1'b0;
    st = 3'h0;
    d = '{default: 8'h00};
    sh = '{default: 8'h00};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("bp after reset", 42'h0, 42'(bp));
    chk("lit after reset", expv(), lit);
    $display("test reset done");
    for (k = 0; k < 8; k++) load(k % 3, {4'(2*k+1), 4'(2*k)});
    $display("test all codes done");
    for (k = 0; k < 12; k++) load(int'($unsigned($random(seed)) % 3), 8'($random(seed)));
    $display("test random bytes done");
    bp_period();
    bp_period();
    $display("test backplane done");
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("seg in reset", 42'h0, seg);
    rst_n = 1'b1;
    sh = '{default: 8'h00};
    @(negedge clk);
    chk("lit after second reset", expv(), lit);
    load(2, 8'h21);
    $display("test second reset done");
    wrap_up();
  end
endmodule
